/* rtl/ciw_card_wrapper.sv */
`timescale 1ns/10ps

// Summary of operation
// - Interface disabled: all pad drivers tri-stated
// - Idle-hold set: pads pulled down, lines low
// - Idle-hold clear: protocol core owns pads
// - Idle-hold ignored while interface disabled
// - Disabled idle: pull-downs on, controls zero
// - Enable set returns pads to core if idle-hold clear
// - Bit 4 selects weak or strong pull-up
// - Pad-mode bit: low current except clock pad
// - Sync-select bit routes pads to sync logic
// - Drive code resets 00, acts only enabled
module ciw_card_wrapper #(
  parameter int ADDR_W = 12,
  parameter int NUM_PINS = 5,
  parameter int CLK_PIN = 1
) (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [NUM_PINS-1:0] async_out,
  input wire logic [NUM_PINS-1:0] async_oe_n,
  input wire logic [NUM_PINS-1:0] async_pu_en,
  input wire logic [NUM_PINS-1:0] async_pd_en,
  output logic [NUM_PINS-1:0] async_in,
  input wire logic [NUM_PINS-1:0] sync_out,
  input wire logic [NUM_PINS-1:0] sync_oe_n,
  input wire logic [NUM_PINS-1:0] sync_pu_en,
  input wire logic [NUM_PINS-1:0] sync_pd_en,
  output logic [NUM_PINS-1:0] sync_in,
  input wire logic [NUM_PINS-1:0] pad_in,
  output logic [NUM_PINS-1:0] pad_out,
  output logic [NUM_PINS-1:0] pad_oe_n,
  output logic [NUM_PINS-1:0] pad_pu_en,
  output logic [NUM_PINS-1:0] pad_pd_en,
  output logic [NUM_PINS-1:0] pad_low_current_hysteresis,
  output logic strong_pullup_select,
  output logic low_card_clock_flag,
  output logic sync_mode,
  output logic [1:0] pad_drive_sel
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic aw_got;
    logic [ADDR_W-1:0] awaddr;
    logic w_got;
    logic [7:0] wdata;
    logic wstrb0;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [7:0] rdata;
    logic [1:0] rresp;
    logic [7:0] ctl;
    logic [1:0] drive;
    logic [NUM_PINS-1:0] p_out;
    logic [NUM_PINS-1:0] p_oe_n;
    logic [NUM_PINS-1:0] p_pu;
    logic [NUM_PINS-1:0] p_pd;
    logic [NUM_PINS-1:0] p_lc;
    logic [1:0] p_drive;
  } ciw_state_s;

  ciw_state_s st_ff;
  ciw_state_s nxt_st;

  function automatic ciw_pkg::ciw_sel_e decode(
    input logic [ADDR_W-1:0] addr
  );
    logic [ADDR_W-3:0] idx;
    idx = addr[ADDR_W-1:2];
    if (idx == (ADDR_W-2)'(ciw_pkg::CARD_WRAPPER_CONTROL_IDX)) begin
      return ciw_pkg::CIW_SEL_CTL;
    end
    if (idx == (ADDR_W-2)'(ciw_pkg::CARD_PAD_DRIVE_CONTROL_IDX)) begin
      return ciw_pkg::CIW_SEL_PAD;
    end
    return ciw_pkg::CIW_SEL_NONE;
  endfunction : decode

  // ----------------------------------------------------------------
  // Pad ownership
  // ----------------------------------------------------------------
  // Decoded once for the pad mux and the input steering; the registered pad mux follows the steering one cycle later
  typedef enum logic [1:0] {
    CIW_OWN_OFF = 2'h0,
    CIW_OWN_IDLE = 2'h1,
    CIW_OWN_ASYNC = 2'h3,
    CIW_OWN_SYNC = 2'h2
  } ciw_owner_e;

  function automatic ciw_owner_e pad_owner(
    input logic [7:0] ctl
  );
    // Idle-hold and mode select count only once the interface is on
    if (!ctl[ciw_pkg::CTL_IF_ENABLE_BIT]) begin
      return CIW_OWN_OFF;
    end
    if (ctl[ciw_pkg::CTL_AUTO_IDLE_HOLD_BIT]) begin
      return CIW_OWN_IDLE;
    end
    if (ctl[ciw_pkg::CTL_SYNC_SELECT_BIT]) begin
      return CIW_OWN_SYNC;
    end
    return CIW_OWN_ASYNC;
  endfunction : pad_owner

  logic if_en;
  logic sync_sel;
  ciw_owner_e owner;

  assign if_en = st_ff.ctl[ciw_pkg::CTL_IF_ENABLE_BIT];
  assign sync_sel = st_ff.ctl[ciw_pkg::CTL_SYNC_SELECT_BIT];
  assign owner = pad_owner(st_ff.ctl);

  // ----------------------------------------------------------------
  // Bus handshakes
  // ----------------------------------------------------------------
  // A new write is held off until the response has been taken, so at
  // most one write is in flight; address and data may come in any order.
  assign s_axi_awready = ~st_ff.aw_got & ~st_ff.bvalid;
  assign s_axi_wready = ~st_ff.w_got & ~st_ff.bvalid;
  assign s_axi_arready = ~st_ff.rvalid;
  assign s_axi_bvalid = st_ff.bvalid;
  assign s_axi_bresp = st_ff.bresp;
  assign s_axi_rvalid = st_ff.rvalid;
  assign s_axi_rresp = st_ff.rresp;
  assign s_axi_rdata = {24'h000000, st_ff.rdata};

  // ----------------------------------------------------------------
  // Pad side
  // ----------------------------------------------------------------
  assign pad_out = st_ff.p_out;
  assign pad_oe_n = st_ff.p_oe_n;
  assign pad_pu_en = st_ff.p_pu;
  assign pad_pd_en = st_ff.p_pd;
  assign pad_low_current_hysteresis = st_ff.p_lc;
  assign pad_drive_sel = st_ff.p_drive;
  assign strong_pullup_select =
    st_ff.ctl[ciw_pkg::CTL_STRONG_PULLUP_BIT];
  assign low_card_clock_flag =
    st_ff.ctl[ciw_pkg::CTL_LOW_CLOCK_BIT];
  assign sync_mode = sync_sel;
  // Inputs reach only the logic that owns the pads; the other sees zero
  assign async_in = (owner == CIW_OWN_ASYNC) ? pad_in : '0;
  assign sync_in = (owner == CIW_OWN_SYNC) ? pad_in : '0;

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    logic aw_now;
    logic w_now;
    logic [ADDR_W-1:0] wa;
    logic [7:0] wd;
    logic ws;
    ciw_pkg::ciw_sel_e wsel;
    ciw_pkg::ciw_sel_e rsel;
    aw_now = s_axi_awvalid & s_axi_awready;
    w_now = s_axi_wvalid & s_axi_wready;
    wa = aw_now ? s_axi_awaddr : st_ff.awaddr;
    wd = w_now ? s_axi_wdata[7:0] : st_ff.wdata;
    ws = w_now ? s_axi_wstrb[0] : st_ff.wstrb0;
    wsel = decode(wa);
    rsel = decode(s_axi_araddr);
    nxt_st = st_ff;

    if (aw_now) begin
      nxt_st.aw_got = 1'b1;
      nxt_st.awaddr = s_axi_awaddr;
    end
    if (w_now) begin
      nxt_st.w_got = 1'b1;
      nxt_st.wdata = s_axi_wdata[7:0];
      nxt_st.wstrb0 = s_axi_wstrb[0];
    end

    if (st_ff.bvalid && s_axi_bready) begin
      nxt_st.bvalid = 1'b0;
    end
    if ((aw_now | st_ff.aw_got) && (w_now | st_ff.w_got)) begin
      nxt_st.aw_got = 1'b0;
      nxt_st.w_got = 1'b0;
      nxt_st.bvalid = 1'b1;
      nxt_st.bresp = ciw_pkg::RESP_OKAY;
      unique case (wsel)
        ciw_pkg::CIW_SEL_CTL: begin
          if (ws) begin
            nxt_st.ctl = wd & ciw_pkg::CTL_WMASK;
          end
        end
        ciw_pkg::CIW_SEL_PAD: begin
          if (ws) begin
            nxt_st.drive = wd[1:0];
          end
        end
        ciw_pkg::CIW_SEL_NONE: begin
          nxt_st.bresp = ciw_pkg::RESP_SLVERR;
        end
      endcase
    end

    if (st_ff.rvalid && s_axi_rready) begin
      nxt_st.rvalid = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      nxt_st.rvalid = 1'b1;
      nxt_st.rresp = ciw_pkg::RESP_OKAY;
      unique case (rsel)
        ciw_pkg::CIW_SEL_CTL: begin
          nxt_st.rdata = st_ff.ctl;
        end
        ciw_pkg::CIW_SEL_PAD: begin
          nxt_st.rdata = {6'h00, st_ff.drive};
        end
        ciw_pkg::CIW_SEL_NONE: begin
          nxt_st.rdata = 8'h00;
          nxt_st.rresp = ciw_pkg::RESP_SLVERR;
        end
      endcase
    end

    // Pad mux; registered so pads never see a glitch from the decode
    for (int i = 0; i < NUM_PINS; i++) begin
      unique case (owner)
        CIW_OWN_OFF: begin
          // Idle-hold plays no part here
          nxt_st.p_out[i] = 1'b0;
          nxt_st.p_oe_n[i] = 1'b1;
          nxt_st.p_pu[i] = 1'b0;
          nxt_st.p_pd[i] = 1'b1;
        end
        CIW_OWN_IDLE: begin
          // Driven low as well as pulled down, so no line floats
          nxt_st.p_out[i] = 1'b0;
          nxt_st.p_oe_n[i] = 1'b0;
          nxt_st.p_pu[i] = 1'b0;
          nxt_st.p_pd[i] = 1'b1;
        end
        CIW_OWN_SYNC: begin
          nxt_st.p_out[i] = sync_out[i];
          nxt_st.p_oe_n[i] = sync_oe_n[i];
          nxt_st.p_pu[i] = sync_pu_en[i];
          nxt_st.p_pd[i] = sync_pd_en[i];
        end
        CIW_OWN_ASYNC: begin
          nxt_st.p_out[i] = async_out[i];
          nxt_st.p_oe_n[i] = async_oe_n[i];
          nxt_st.p_pu[i] = async_pu_en[i];
          nxt_st.p_pd[i] = async_pd_en[i];
        end
      endcase
      // Clock pad keeps full drive and normal hysteresis
      nxt_st.p_lc[i] = (i != CLK_PIN) &&
        st_ff.ctl[ciw_pkg::CTL_LOW_CURRENT_BIT];
    end
    // Undefined codes pass through unchanged
    nxt_st.p_drive = if_en ? st_ff.drive : ciw_pkg::PAD_DRIVE_OFF;
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      st_ff <= '0;
      st_ff.ctl <= ciw_pkg::CTL_RESET;
      st_ff.drive <= ciw_pkg::PAD_DRIVE_RESET;
      st_ff.p_oe_n <= '1;
      st_ff.p_pd <= '1;
      st_ff.p_drive <= ciw_pkg::PAD_DRIVE_OFF;
    end else begin
      st_ff <= nxt_st;
    end
  end

endmodule : ciw_card_wrapper

/* rtl/ciw_pkg.sv */
package ciw_pkg;

  // ----------------------------------------------------------------
  // Register indices; byte address is four times the index
  // ----------------------------------------------------------------
  localparam logic [7:0] CARD_WRAPPER_CONTROL_IDX = 8'h80;
  localparam logic [7:0] CARD_PAD_DRIVE_CONTROL_IDX = 8'h81;

  // ----------------------------------------------------------------
  // Field positions of card_wrapper_control
  // ----------------------------------------------------------------
  localparam int CTL_IF_ENABLE_BIT = 7;
  localparam int CTL_AUTO_IDLE_HOLD_BIT = 6;
  localparam int CTL_STRONG_PULLUP_BIT = 4;
  localparam int CTL_LOW_CLOCK_BIT = 2;
  localparam int CTL_LOW_CURRENT_BIT = 1;
  localparam int CTL_SYNC_SELECT_BIT = 0;

  // ----------------------------------------------------------------
  // Reset values and writable masks
  // ----------------------------------------------------------------
  localparam logic [7:0] CTL_RESET = 8'h00;
  localparam logic [1:0] PAD_DRIVE_RESET = 2'h0;
  localparam logic [7:0] CTL_WMASK = 8'hd7;
  localparam logic [1:0] PAD_DRIVE_OFF = 2'h0;

  // ----------------------------------------------------------------
  // AXI response codes and decoder result
  // ----------------------------------------------------------------
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    CIW_SEL_NONE = 2'h0,
    CIW_SEL_CTL = 2'h1,
    CIW_SEL_PAD = 2'h3
  } ciw_sel_e;

endpackage : ciw_pkg

/* verif/ciw_card_model.sv */
`timescale 1ns/10ps
module ciw_card_model #(
  parameter int NUM_PINS = 5
) (
  input wire logic core_clk,
  input wire logic card_on,
  input wire logic [NUM_PINS-1:0] card_val,
  input wire logic [NUM_PINS-1:0] pad_out,
  input wire logic [NUM_PINS-1:0] pad_oe_n,
  input wire logic [NUM_PINS-1:0] pad_pu_en,
  input wire logic [NUM_PINS-1:0] pad_pd_en,
  output logic [NUM_PINS-1:0] pad_in
);
  logic [NUM_PINS-1:0] flt_ff = '0;
  logic [NUM_PINS-1:0] rel;
  // A floating line toggles so a stale value is never mistaken for data
  always @(posedge core_clk) flt_ff <= ~flt_ff;
  assign rel = card_on ? card_val : (pad_pu_en & ~pad_pd_en)
    | (~pad_pu_en & ~pad_pd_en & flt_ff);
  assign pad_in = (~pad_oe_n & pad_out) | (pad_oe_n & rel);
endmodule : ciw_card_model

/* verif/ciw_card_wrapper_properties.sv */
`timescale 1ns/10ps
// ----
// Port checks
// ----
module ciw_card_wrapper_properties #(
  parameter int ADDR_W = 12,
  parameter int NUM_PINS = 5,
  parameter int CLK_PIN = 1
) (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_rvalid,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [NUM_PINS-1:0] async_out,
  input wire logic [NUM_PINS-1:0] async_oe_n,
  input wire logic [NUM_PINS-1:0] sync_out,
  input wire logic [NUM_PINS-1:0] pad_out,
  input wire logic [NUM_PINS-1:0] pad_oe_n,
  input wire logic [NUM_PINS-1:0] pad_pd_en,
  input wire logic [NUM_PINS-1:0] pad_low_current_hysteresis,
  input wire logic strong_pullup_select,
  input wire logic [1:0] pad_drive_sel
);
  logic [7:0] ctl_ff;
  logic [1:0] drv_ff;
  logic go, en, ih, ca, cs, s4, lc;
  logic [1:0] dx;
  logic [NUM_PINS-1:0] lcm;
  // Mirror assumes address and data are offered together
  assign go = s_axi_awvalid && s_axi_awready && s_axi_wvalid
    && s_axi_wready && s_axi_wstrb[0];
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      ctl_ff <= 8'h00;
      drv_ff <= 2'h0;
    end else if (go && (s_axi_awaddr >> 2) == ADDR_W'(8'h80)) begin
      ctl_ff <= s_axi_wdata[7:0] & 8'hd7;
    end else if (go && (s_axi_awaddr >> 2) == ADDR_W'(8'h81)) begin
      drv_ff <= s_axi_wdata[1:0];
    end
  end
  assign en = ctl_ff[7];
  assign ih = en && ctl_ff[6];
  assign ca = en && !ctl_ff[6] && !ctl_ff[0];
  assign cs = en && !ctl_ff[6] && ctl_ff[0];
  assign s4 = ctl_ff[4];
  assign lc = ctl_ff[1];
  assign dx = en ? drv_ff : 2'h0;
  assign lcm = lc ? ~(NUM_PINS'(1) << CLK_PIN) : '0;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_b);
  a_off_tristate: assert property (
    !$past(en) |-> &pad_oe_n && pad_out == '0)
    else $error("pads driven while disabled");
  a_off_pulldown: assert property (
    !$past(en) |-> &pad_pd_en) else $error("pull-downs off");
  a_idle_low: assert property (
    $past(ih) |-> pad_oe_n == '0 && pad_out == '0 && &pad_pd_en)
    else $error("idle hold not low");
  a_async_route: assert property (
    $past(ca) |-> pad_out == $past(async_out)
    && pad_oe_n == $past(async_oe_n)) else $error("async route");
  a_sync_route: assert property (
    $past(cs) |-> pad_out == $past(sync_out)) else $error("sync route");
  a_pullup_sel: assert property (
    $stable(s4) |-> strong_pullup_select == s4) else $error("pull-up");
  a_low_current: assert property (
    $stable(lc) |-> pad_low_current_hysteresis == lcm)
    else $error("low current mask");
  a_drive_gate: assert property (
    $stable(dx) |-> pad_drive_sel == dx) else $error("drive code");
  a_rsvd_read: assert property (
    s_axi_rvalid |-> s_axi_rdata[31:8] == '0 && !s_axi_rdata[5]
    && !s_axi_rdata[3]) else $error("reserved bits set");
  c_idle: cover property (ih);
  c_async: cover property (ca);
  c_sync: cover property (cs);
endmodule : ciw_card_wrapper_properties

bind ciw_card_wrapper ciw_card_wrapper_properties #(.ADDR_W(ADDR_W),
  .NUM_PINS(NUM_PINS), .CLK_PIN(CLK_PIN)) ciw_props_inst (.*);

/* verif/ciw_card_wrapper_tb.sv */
`timescale 1ns/10ps
module ciw_card_wrapper_tb;
  logic core_clk, rst_b, card_on, s_axi_awvalid, s_axi_awready;
  logic s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic strong_pullup_select, low_card_clock_flag, sync_mode;
  logic [11:0] s_axi_awaddr, s_axi_araddr;
  logic [2:0] s_axi_awprot, s_axi_arprot;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, pad_drive_sel;
  logic [4:0] async_out, async_oe_n, async_pu_en, async_pd_en, async_in;
  logic [4:0] sync_out, sync_oe_n, sync_pu_en, sync_pd_en, sync_in;
  logic [4:0] pad_in, pad_out, pad_oe_n, pad_pu_en, pad_pd_en, card_val;
  logic [4:0] pad_low_current_hysteresis;
  logic [19:0] pads;
  logic [7:0] cv [6] = '{8'h00, 8'h40, 8'hc0, 8'h80, 8'h81, 8'hc1};
  logic [19:0] ev [6] = '{20'h07c1f, 20'h07c1f, 20'h0001f, 20'hab070,
    20'h54782, 20'h0001f};
  int n_mismatch = 0;
  int n_tests = 0;
  assign pads = {pad_out, pad_oe_n, pad_pu_en, pad_pd_en};
  ciw_card_wrapper ciw_card_wrapper_inst (.*);
  ciw_card_model ciw_card_model_inst (.*);
  initial begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_tests++;
    if (g !== e) begin
      n_mismatch++;
      $display("Error at %0t: got %h, expected %h", $time, g, e);
    end
  endtask : chk
  task automatic wr(input logic [11:0] a, input logic [31:0] d,
    input logic [1:0] er);
    @(posedge core_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    forever begin
      @(posedge core_clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) break;
    end
    s_axi_bready <= 1'b0;
    chk(s_axi_bresp, er);
  endtask : wr
  task automatic rd(input logic [11:0] a, input logic [31:0] e,
    input logic [1:0] er);
    @(posedge core_clk);
    s_axi_araddr <= a;
    {s_axi_arvalid, s_axi_rready} <= 2'h3;
    forever begin
      @(posedge core_clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) break;
    end
    s_axi_rready <= 1'b0;
    chk(s_axi_rdata, e);
    chk(s_axi_rresp, er);
  endtask : rd
  task automatic stop_test;
    $display("Checks %0d, mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : stop_test
  initial begin
    #40000;
    n_mismatch++;
    stop_test();
  end
  initial begin
    {rst_b, card_on, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
    {s_axi_arvalid, s_axi_rready, s_axi_awprot, s_axi_arprot} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    s_axi_wstrb = 4'hf;
    {async_out, async_oe_n, async_pu_en, async_pd_en} = 20'hab070;
    {sync_out, sync_oe_n, sync_pu_en, sync_pd_en} = 20'h54782;
    card_val = 5'h1b;
    repeat (20) @(posedge core_clk);
    rst_b <= 1'b1;
    rd(12'h200, 32'h0, 2'h0);
    rd(12'h204, 32'h0, 2'h0);
    wr(12'h204, 32'hffff_ffff, 2'h0);
    rd(12'h204, 32'h3, 2'h0);
    wr(12'h208, 32'h1, 2'h2);
    rd(12'h208, 32'h0, 2'h2);
    for (int i = 0; i < 6; i++) begin
      card_on <= cv[i][7];
      wr(12'h200, {24'h0, cv[i]}, 2'h0);
      @(negedge core_clk);
      chk(pads, ev[i]);
      chk(async_in, cv[i] == 8'h80 ? pad_in : 5'h0);
      chk(sync_in, cv[i] == 8'h81 ? pad_in : 5'h0);
      chk(sync_mode, cv[i][0]);
      chk(pad_drive_sel, cv[i][7] ? 2'h3 : 2'h0);
    end
    wr(12'h200, 32'hff, 2'h0);
    rd(12'h200, 32'hd7, 2'h0);
    @(negedge core_clk);
    chk({strong_pullup_select, low_card_clock_flag}, 2'h3);
    chk(pad_low_current_hysteresis, 5'h1d);
    wr(12'h200, 32'h04, 2'h0);
    @(negedge core_clk);
    chk({strong_pullup_select, low_card_clock_flag}, 2'h1);
    chk(pad_low_current_hysteresis, 5'h00);
    stop_test();
  end
endmodule : ciw_card_wrapper_tb
